// file: adc_ctrl.sv
// Controller driving a 1M x 4 asynchronous DRAM through its pins.
// Assumes pin inputs synchronous to ref_clk; data pins split into in/out/oe.
`timescale 1ns/1ns
`default_nettype none
`include "adc_types_map.svh"
// Summary of operation
// R01 - After reset wait power-up pause, then eight row-strobe cycles.
// R02 - After idle beyond the long interval, issue eight wakeup row cycles.
// R03 - Row field on row-strobe fall, column field on column-strobe fall.
// R04 - Row strobe falls first; column strobe follows after row-to-column delay.
// R05 - Device ignores column strobe until row address hold met.
// R06 - Reads hold write strobe high before and through the column strobe.
// R07 - Read data valid once column strobe and output gate are asserted.
// R08 - Device drives data only while column strobe and gate both low.
// R09 - Strobes keep minimum widths; row strobe precharges before next cycle.
// R10 - Early write: write strobe low before column strobe; data then captured. Here both strobes fall on the same edge.
// R11 - Device keeps outputs off during early write.
// R12 - Late write: gate high, write strobe falls after column strobe.
// R13 - Keep both strobes low for their lead times after write strobe falls.
// R14 - Read-write: read after column fall, then write same location.
// R15 - Page mode: row held low, each column fall opens new column.
// R16 - Column precharge between page cycles; operations mixed freely.
// R17 - End page by raising row strobe after column; bound page duration.
// R18 - Refresh one row every distributed refresh interval.
// R19 - Burst refresh alternative; this design uses distributed refresh.
// R20 - Any normal access refreshes its whole row.
// R21 - Row-only refresh with column high, rows from own counter.
// R22 - Column-before-row refresh uses internal counter; not issued here.
// R23 - Hidden refresh keeps column low while row cycles; not issued here.
// R24 - Four data bits move in parallel per access.
module adc_ctrl (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire adc_pkg::adc_op_t req_op,
  input wire adc_pkg::adc_addr_t req_addr,
  input wire adc_pkg::adc_data_t req_wdata,
  input wire logic req_page,
  output logic req_ready,
  output logic rsp_valid,
  output adc_pkg::adc_data_t rsp_rdata,
  output logic init_done,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic oe_n,
  output logic [9:0] address_pins,
  input wire logic [3:0] data_pins_in,
  output logic [3:0] data_pins_out,
  output logic data_pins_oe_n
);
  import adc_pkg::*;

  typedef enum logic [10:0] {
    ST_PWRUP = 11'h001,
    ST_WAKE_LOW = 11'h002,
    ST_WAKE_HIGH = 11'h004,
    ST_IDLE = 11'h008,
    ST_ROW = 11'h010,
    ST_COL = 11'h020,
    ST_LATE = 11'h040,
    ST_WHOLD = 11'h080,
    ST_CASPRE = 11'h100,
    ST_PRECH = 11'h200,
    ST_REF = 11'h400
  } adc_state_t;

  adc_state_t st_q, st_d;
  logic ras_n_q, cas_n_q, we_n_q, oe_n_q, doe_n_q;
  logic [9:0] addr_q;
  logic [3:0] dout_q, rdata_q;
  logic ready_q, rsp_q, init_q;
  logic [3:0] wake_q;
  logic [9:0] ref_row_q;
  logic [23:0] ref_cnt_q, idle_cnt_q, page_cnt_q;
  adc_op_t op_q;
  logic [9:0] col_q, addr_row_q;
  logic [3:0] wd_q;
  logic page_q, start_q, ref_pend_q;
  adc_op_t op_n;

  logic t_load;
  logic [23:0] t_val;
  logic t_done;

  adc_timer u_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .load(t_load),
    .value(t_val),
    .done(t_done)
  );

  function automatic logic [23:0] cyc(input int n);
    cyc = 24'(n);
  endfunction : cyc

  wire ref_due = ref_pend_q;
  wire ref_quiet = !ref_pend_q && (ref_cnt_q != 24'h000000);
  wire idle_long = (idle_cnt_q >= cyc(`ADC_IDLE_CYC));
  wire page_ok = (page_cnt_q < cyc(`ADC_RASP_CYC - 64));
  wire take = (st_q == ST_IDLE) && req_valid && ready_q;
  wire page_take = (st_q == ST_CASPRE) && t_done && req_valid && ready_q &&
    page_q && req_page && (req_addr[19:10] == addr_row_q);
  // A page access uses its new operation and data at the strobe edge
  assign op_n = page_take ? req_op : op_q;
  wire [3:0] wd_n = page_take ? req_wdata : wd_q;
  wire is_wr_early = (op_n == ADC_OP_EARLY_WRITE);
  wire is_late = (op_q == ADC_OP_LATE_WRITE) || (op_q == ADC_OP_READ_WRITE);

  always_comb begin
    st_d = st_q;
    t_load = 1'b0;
    t_val = 24'h000000;
    case (st_q)
      ST_PWRUP: begin
        if (!start_q) begin
          t_load = 1'b1;
          t_val = cyc(`ADC_PWRUP_CYC); // R01
        end else if (t_done) begin
          st_d = ST_WAKE_LOW; // R01
          t_load = 1'b1;
          t_val = cyc(`ADC_TRAS_CYC);
        end
      end
      ST_WAKE_LOW: begin
        if (t_done) begin
          st_d = ST_WAKE_HIGH;
          t_load = 1'b1;
          t_val = cyc(`ADC_TRP_CYC); // R09
        end
      end
      ST_WAKE_HIGH: begin
        if (t_done) begin
          st_d = (wake_q == 4'h1) ? ST_IDLE : ST_WAKE_LOW;
          t_load = 1'b1;
          t_val = cyc(`ADC_TRAS_CYC);
        end
      end
      ST_IDLE: begin
        if (take) begin
          st_d = ST_ROW; // R04
          t_load = 1'b1;
          t_val = cyc(`ADC_TRCD_CYC);
        end else if (idle_long) begin
          st_d = ST_WAKE_LOW; // R02
          t_load = 1'b1;
          t_val = cyc(`ADC_TRAS_CYC);
        end else if (ref_due) begin
          st_d = ST_REF; // R18 R21
          t_load = 1'b1;
          t_val = cyc(`ADC_TRAS_CYC);
        end
      end
      ST_ROW: begin
        if (t_done) begin
          st_d = ST_COL;
          t_load = 1'b1;
          t_val = cyc(`ADC_TRAS_CYC);
        end
      end
      ST_COL: begin
        if (t_done) begin
          st_d = is_late ? ST_LATE : ST_WHOLD;
          t_load = 1'b1;
          t_val = is_late ? cyc(`ADC_TCWD_CYC) : cyc(`ADC_TRWL_CYC);
        end
      end
      ST_LATE: begin
        if (t_done) begin
          st_d = ST_WHOLD; // R14
          t_load = 1'b1;
          t_val = cyc(`ADC_TRWL_CYC + `ADC_TWP_CYC);
        end
      end
      ST_WHOLD: begin
        if (t_done) begin
          st_d = ST_CASPRE; // R13
          t_load = 1'b1;
          t_val = cyc(`ADC_TCP_CYC);
        end
      end
      ST_CASPRE: begin
        if (page_take) begin
          st_d = ST_COL; // R15
          t_load = 1'b1;
          t_val = cyc(`ADC_TCAS_CYC);
        end else if (t_done) begin
          st_d = ST_PRECH; // R17
          t_load = 1'b1;
          t_val = cyc(`ADC_TRP_CYC);
        end
      end
      ST_PRECH: begin
        if (t_done) begin
          st_d = ST_IDLE; // R09
        end
      end
      ST_REF: begin
        if (t_done) begin
          st_d = ST_PRECH; // R21
          t_load = 1'b1;
          t_val = cyc(`ADC_TRP_CYC);
        end
      end
      default: begin
        st_d = ST_PWRUP;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_q <= ST_PWRUP;
    end else begin
      st_q <= st_d;
    end
  end

  // Power-up pause is loaded on the first edge after reset release
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wake_q <= 4'h0;
      init_q <= 1'b0;
      idle_cnt_q <= 24'h000000;
      ref_cnt_q <= 24'h000000;
      ref_row_q <= 10'h000;
      page_cnt_q <= 24'h000000;
      ref_pend_q <= 1'b0;
    end else begin
      if ((st_q == ST_PWRUP) || (st_q == ST_IDLE && st_d == ST_WAKE_LOW)) begin
        wake_q <= 4'(`ADC_WAKE_CYCLES); // R01
      end else if (st_q == ST_WAKE_HIGH && t_done) begin
        wake_q <= wake_q - 4'h1;
      end
      if (st_q == ST_WAKE_HIGH && t_done && wake_q == 4'h1) begin
        init_q <= 1'b1;
      end
      if (st_q == ST_IDLE) begin
        idle_cnt_q <= idle_long ? 24'h000000 : idle_cnt_q + 24'h000001;
      end else begin
        idle_cnt_q <= 24'h000000; // R02
      end
      // Free-running interval keeps the average; a late refresh stays pending
      if (!init_q || ref_cnt_q == 24'h000000) begin
        ref_cnt_q <= cyc(`ADC_REF_CYC - 1); // R18 R19
      end else begin
        ref_cnt_q <= ref_cnt_q - 24'h000001;
      end
      if (init_q && ref_cnt_q == 24'h000000) begin
        ref_pend_q <= 1'b1;
      end else if (st_q == ST_REF && st_d == ST_PRECH) begin
        ref_pend_q <= 1'b0;
      end
      if (st_q == ST_REF && st_d == ST_PRECH) begin
        ref_row_q <= ref_row_q + 10'h001; // R21
      end
      if (st_q == ST_ROW) begin
        page_cnt_q <= 24'h000000;
      end else if (!ras_n_q) begin
        page_cnt_q <= page_cnt_q + 24'h000001; // R17
      end
    end
  end

  wire pulse_row = (st_q == ST_IDLE) && take;
  wire row_strobe_low = (st_d == ST_WAKE_LOW) || (st_d == ST_ROW) ||
    (st_d == ST_COL) || (st_d == ST_LATE) || (st_d == ST_WHOLD) ||
    (st_d == ST_CASPRE) || (st_d == ST_REF);
  wire col_strobe_low = (st_d == ST_COL) || (st_d == ST_LATE) ||
    (st_d == ST_WHOLD);
  wire col_edge = col_strobe_low && cas_n_q;
  wire late_edge = (st_q == ST_LATE) && (st_d == ST_WHOLD);
  wire [9:0] addr_d = (st_d == ST_REF) ? ref_row_q :
    pulse_row ? req_addr[19:10] :
    page_take ? req_addr[9:0] :
    (st_d == ST_COL) ? col_q : addr_q;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ras_n_q <= 1'b1;
      cas_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      doe_n_q <= 1'b1;
      addr_q <= 10'h000;
      dout_q <= 4'h0;
      rdata_q <= 4'h0;
      ready_q <= 1'b0;
      rsp_q <= 1'b0;
      op_q <= ADC_OP_READ;
      col_q <= 10'h000;
      addr_row_q <= 10'h000;
      wd_q <= 4'h0;
      page_q <= 1'b0;
    end else begin
      ras_n_q <= !row_strobe_low; // R04
      cas_n_q <= !col_strobe_low; // R21
      addr_q <= addr_d; // R03
      if (pulse_row || page_take) begin
        op_q <= req_op;
        col_q <= req_addr[9:0];
        addr_row_q <= req_addr[19:10];
        wd_q <= req_wdata; // R24
        page_q <= req_page;
      end
      ready_q <= init_q && ref_quiet && (st_d == ST_IDLE ||
        (st_q == ST_CASPRE && st_d == ST_CASPRE && page_q && page_ok));
      // R10 R06
      if (col_edge && is_wr_early) begin
        we_n_q <= 1'b0;
      end else if (late_edge) begin
        we_n_q <= 1'b0; // R12
      end else if (st_d == ST_CASPRE || st_d == ST_PRECH) begin
        we_n_q <= 1'b1;
      end
      // Gate low for reads, set high on the same edge as a late write strobe
      if (st_d == ST_COL && op_n != ADC_OP_EARLY_WRITE &&
          op_n != ADC_OP_LATE_WRITE) begin
        oe_n_q <= 1'b0; // R07
      end else if ((st_q == ST_LATE && st_d == ST_WHOLD) ||
          st_d == ST_CASPRE || st_d == ST_PRECH || st_d == ST_IDLE) begin
        oe_n_q <= 1'b1; // R12
      end
      if ((col_edge && is_wr_early) || late_edge) begin
        dout_q <= wd_n;
        doe_n_q <= 1'b0;
      end else if (st_d == ST_CASPRE || st_d == ST_PRECH) begin
        doe_n_q <= 1'b1;
      end
      // Sample read data at column strobe end, or just before late write
      rsp_q <= (st_q == ST_WHOLD) && (st_d == ST_CASPRE); // R16
      if (((st_q == ST_WHOLD && st_d == ST_CASPRE) && op_q == ADC_OP_READ) ||
          (late_edge && op_q == ADC_OP_READ_WRITE)) begin
        rdata_q <= data_pins_in; // R08
      end
    end
  end

  assign ras_n = ras_n_q;
  assign cas_n = cas_n_q;
  assign we_n = we_n_q;
  assign oe_n = oe_n_q;
  assign address_pins = addr_q;
  assign data_pins_out = dout_q;
  assign data_pins_oe_n = doe_n_q;
  assign req_ready = ready_q;
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  assign init_done = init_q;
endmodule : adc_ctrl
`default_nettype wire

// file: adc_types_map.svh
// Timing counts and field positions for the asynchronous DRAM controller.
// Assumes a 50 MHz reference clock (20 ns period).
`ifndef ADC_TYPES_MAP_SVH
`define ADC_TYPES_MAP_SVH
`define ADC_CLK_NS 20
`define ADC_ROW_W 10
`define ADC_COL_W 10
`define ADC_ADDR_W 20
`define ADC_DATA_W 4
`define ADC_PWRUP_NS 2000000
`define ADC_PWRUP_CYC ((`ADC_PWRUP_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)
`define ADC_IDLE_NS 16000000
`define ADC_IDLE_CYC (`ADC_IDLE_NS / `ADC_CLK_NS)
`define ADC_WAKE_CYCLES 8
`define ADC_REF_NS 15600
`define ADC_REF_CYC (`ADC_REF_NS / `ADC_CLK_NS)
`define ADC_RASP_NS 200000
`define ADC_RASP_CYC (`ADC_RASP_NS / `ADC_CLK_NS)
// Least times in cycles (rounded up)
`define ADC_TRCD_CYC 2
`define ADC_TRAS_CYC 5
`define ADC_TRP_CYC 4
`define ADC_TCAS_CYC 2
`define ADC_TCP_CYC 1
`define ADC_TCWD_CYC 3
`define ADC_TWP_CYC 1
`define ADC_TRWL_CYC 1
`endif

// file: adc_pkg.sv
// Types shared by the asynchronous DRAM controller.
// Assumes adc_types_map.svh is on the include path.
`include "adc_types_map.svh"
package adc_pkg;
  typedef logic [`ADC_ADDR_W-1:0] adc_addr_t;
  typedef logic [`ADC_DATA_W-1:0] adc_data_t;
  typedef enum logic [1:0] {
    ADC_OP_READ = 2'h0,
    ADC_OP_EARLY_WRITE = 2'h1,
    ADC_OP_LATE_WRITE = 2'h2,
    ADC_OP_READ_WRITE = 2'h3
  } adc_op_t;
endpackage : adc_pkg

// file: adc_timer.sv
// Down-counting delay timer used by the controller sequencer.
// Assumes a synchronous load and one count per clock.
`timescale 1ns/1ns
`default_nettype none
module adc_timer (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [23:0] value,
  output logic done
);
  logic [23:0] cnt_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 24'h000000;
    end else if (load) begin
      cnt_q <= value;
    end else if (cnt_q != 24'h000000) begin
      cnt_q <= cnt_q - 24'h000001;
    end
  end
  assign done = (cnt_q == 24'h000000);
endmodule : adc_timer
`default_nettype wire

// file: adc_ctrl_props.sv
// Pin timing checker for the DRAM controller.
// Assumes binding to adc_ctrl, pins sampled on ref_clk.
`timescale 1ns/1ns
`default_nettype none
module adc_ctrl_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic rsp_valid,
  input wire logic init_done,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic data_pins_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  AST_IDLE_AFTER_RESET: assert property (
    $fell(reset) |-> ras_n && cas_n && we_n && oe_n && data_pins_oe_n)
    else $error("pins active after reset");
  AST_INIT_NO_CAS: assert property (
    !init_done |-> cas_n) else $error("column strobe before init");
  AST_CAS_AFTER_RAS: assert property (
    $fell(cas_n) |-> !$past(ras_n, 2)) else $error("column before row");
  AST_RAS_MIN_LOW: assert property (
    $fell(ras_n) |-> !ras_n [*5]) else $error("row strobe too short");
  AST_RAS_PRECHARGE: assert property (
    $rose(ras_n) |-> ras_n [*4]) else $error("row precharge short");
  AST_CAS_MIN_LOW: assert property (
    $fell(cas_n) |-> !cas_n [*2]) else $error("column strobe too short");
  AST_RAS_AFTER_CAS: assert property (
    $rose(ras_n) |-> cas_n) else $error("row raised before column");
  AST_GATE_OFF_WRITE: assert property (
    $fell(we_n) |-> oe_n ##1 oe_n) else $error("gate on during write");
  AST_WRITE_LEAD: assert property (
    $fell(we_n) |-> !ras_n && !cas_n ##1 !ras_n && !cas_n)
    else $error("strobes released early");
  AST_DRIVE_ON_WRITE: assert property (
    !cas_n && !we_n |-> !data_pins_oe_n) else $error("write data undriven");
  cover property ($fell(ras_n) && cas_n);
  cover property ($fell(we_n) && !cas_n);
  cover property (rsp_valid);
endmodule : adc_ctrl_chk
bind adc_ctrl adc_ctrl_chk u_adc_ctrl_chk (.ref_clk, .reset, .rsp_valid,
  .init_done, .ras_n, .cas_n, .we_n, .oe_n, .data_pins_oe_n);
`default_nettype wire

// file: adc_dram_model.sv
// Behavioural model of the 1M x 4 memory at the controller pins.
// Assumes the bench resolves the data wire from the controller enable alone.
`timescale 1ns/1ns
`default_nettype none
module adc_dram_model (
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [9:0] address_pins,
  input wire logic [3:0] data_pins_out,
  output logic [3:0] dev_q,
  output logic dev_drv
);
  logic [3:0] mem [logic [19:0]];
  logic [9:0] row_q;
  logic [19:0] loc;
  logic ew_q;
  logic [3:0] last_q = 4'h0;
  // Row latch; any access or row-only cycle refreshes the row
  // Pins are taken just after a strobe edge, once the controller has settled
  always @(negedge ras_n) #1 row_q = address_pins;
  // Column path opens only while a row is held
  always @(negedge cas_n) #1 if (!ras_n) begin
    loc = {row_q, address_pins};
    ew_q = !we_n;
    if (!we_n) mem[loc] = data_pins_out;
  end
  always @(negedge we_n) #2 if (!ras_n && !cas_n && !ew_q) begin
    mem[loc] = data_pins_out;
  end
  // Drive unlatched data only while column strobe and gate are low, outside an early write
  always @(ras_n, cas_n, oe_n, we_n, ew_q, loc) begin
    dev_drv = !cas_n && !oe_n && !ew_q;
    if (dev_drv) last_q = mem.exists(loc) ? mem[loc] : 4'h0;
    dev_q = dev_drv ? last_q : ~last_q;
  end
endmodule : adc_dram_model
`default_nettype wire

// file: tb_adc_ctrl.sv
// Self-checking bench for the DRAM controller with a memory model.
// Assumes the default timing counts of the controller header.
`timescale 1ns/1ns
`default_nettype none
`include "adc_types_map.svh"
module tb_adc_ctrl;
  import adc_pkg::*;
  typedef struct {adc_op_t op; adc_addr_t a; adc_data_t wd, ex;} adc_row_t;
  logic ref_clk, reset, req_valid, req_page, req_ready, rsp_valid;
  logic init_done, ras_n, cas_n, we_n, oe_n, data_pins_oe_n, dev_drv;
  adc_op_t req_op;
  adc_addr_t req_addr;
  adc_data_t req_wdata, rsp_rdata, rd;
  logic [9:0] address_pins;
  logic [3:0] data_pins_in, data_pins_out, dev_q;
  int bad_count, compares, cyc, ras_falls, ref_falls, first_fall, n0, k, t0;
  adc_row_t rows [6] = '{
    '{ADC_OP_EARLY_WRITE, 20'h00000, 4'hA, 4'h0},
    '{ADC_OP_LATE_WRITE, 20'hFFFFF, 4'h5, 4'h0},
    '{ADC_OP_READ, 20'h00000, 4'h0, 4'hA},
    '{ADC_OP_READ, 20'hFFFFF, 4'h0, 4'h5},
    '{ADC_OP_READ_WRITE, 20'h00000, 4'h3, 4'hA},
    '{ADC_OP_READ, 20'h00000, 4'h0, 4'h3}};
  adc_ctrl u_adc_ctrl (.ref_clk, .reset, .req_valid, .req_op, .req_addr,
    .req_wdata, .req_page, .req_ready, .rsp_valid, .rsp_rdata, .init_done,
    .ras_n, .cas_n, .we_n, .oe_n, .address_pins, .data_pins_in,
    .data_pins_out, .data_pins_oe_n);
  adc_dram_model u_adc_dram_model (.ras_n, .cas_n, .we_n, .oe_n,
    .address_pins, .data_pins_out, .dev_q, .dev_drv);
  assign data_pins_in = data_pins_oe_n ? dev_q : data_pins_out;
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  task give_verdict;
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic do_req(input adc_op_t op, input adc_addr_t a,
    input adc_data_t wd, input logic pg, output adc_data_t r);
    int n;
    @(negedge ref_clk);
    req_valid = 1'b1;
    req_op = op;
    req_addr = a;
    req_wdata = wd;
    req_page = pg;
    n = 0;
    while (req_ready !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
    chk("rsp_valid", 1, rsp_valid);
    r = rsp_rdata;
  endtask : do_req
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 120000) begin
      bad_count++;
      give_verdict;
    end
  end
  always @(negedge ras_n) begin
    ras_falls++;
    if (cas_n) ref_falls++;
    if (ras_falls == 1) first_fall = cyc;
  end
  always @(negedge ref_clk) if (!reset && dev_drv) begin
    chk("bus_clash", 1, data_pins_oe_n);
  end
  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    req_valid = 1'b0;
    req_op = ADC_OP_READ;
    req_addr = '0;
    req_wdata = '0;
    req_page = 1'b0;
    repeat (10) @(negedge ref_clk);
    chk("ras_rst", 1, ras_n);
    reset = 1'b0;
    t0 = cyc;
    while (init_done !== 1'b1) @(negedge ref_clk);
    chk("pause", 1, first_fall >= t0 + `ADC_PWRUP_CYC);
    chk("wake", 1, ras_falls >= `ADC_WAKE_CYCLES);
    foreach (rows[i]) begin
      do_req(rows[i].op, rows[i].a, rows[i].wd, 1'b0, rd);
      if (rows[i].op inside {ADC_OP_READ, ADC_OP_READ_WRITE}) begin
        chk("rdata", rows[i].ex, rd);
      end
    end
    n0 = ref_falls;
    k = 0;
    while (ref_falls == n0 && k < `ADC_REF_CYC + 100) begin
      @(negedge ref_clk);
      k++;
    end
    chk("refresh", 1, ref_falls > n0);
    n0 = ras_falls;
    do_req(ADC_OP_EARLY_WRITE, 20'h2A801, 4'h9, 1'b1, rd);
    do_req(ADC_OP_READ, 20'h2A801, 4'h0, 1'b1, rd);
    chk("page_rd", 4'h9, rd);
    chk("page_ras", n0 + 1, ras_falls);
    @(negedge ref_clk);
    reset = 1'b1;
    @(negedge ref_clk);
    chk("init_rst", 0, init_done);
    chk("cas_rst", 1, cas_n);
    give_verdict;
  end
endmodule : tb_adc_ctrl
`default_nettype wire
